//--- src/luma_nr_consts.svh
/*
  Offsets, field positions, reset values and counts for the luma noise
  reduction stage. Assumes it is included by its bare name wherever needed.
*/
`ifndef LUMA_NR_CONSTS_SVH
`define LUMA_NR_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_GAIN      8'ha3
`define IDX_THR_BLK   8'ha4
`define IDX_MODE_OFF  8'ha5
`define CFG_RESET     8'h00

`define GAIN_BORD_LSB 0
`define GAIN_DATA_LSB 4
`define THR_LSB       0
`define BORDER_BIT    6
`define BLK16_BIT     7
`define SEL_LSB       0
`define MODE_BIT      4
`define OFF_LSB       4

`define CYC_PER_PIX   2
`define BLK_SMALL     5'h08
`define BLK_LARGE     5'h10
`define HALF_NARROW   5'h01
`define HALF_WIDE     5'h02
`define GAIN_MAX      4'h8
`define CORE_SHIFT    3
`define SHARP_SHIFT   4
`define LUMA_MAX      8'hff

`endif

//--- src/luma_nr_pkg.sv
/*
  Types for the luma noise reduction stage: pixel carriers and filter choice.
  Assumes the constants header is available to the design file.
*/
package luma_nr_pkg;

  typedef struct packed {
    logic       valid;
    logic       sol;
    logic       sof;
    logic [7:0] luma;
  } pix_in_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] luma;
  } pix_out_t;

  typedef enum logic [2:0] {
    FILT_HALF3  = 3'b000,
    FILT_FULL3  = 3'b001,
    FILT_WIDE3  = 3'b010,
    FILT_HALF5  = 3'b011,
    FILT_QUART5 = 3'b100,
    FILT_DIFF   = 3'b101,
    FILT_HWIDE  = 3'b110,
    FILT_OFF    = 3'b111
  } filt_sel_t;

endpackage

//--- src/sd_luma_noise_reduction.sv
/*
  Standard definition luma noise reduction with an Avalon-MM register slave.
  Assumes a pixel source sending one pixel per two valid cycles, luma on the
  first, with start-of-line and start-of-field flags on a line's first cycle.
*/
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "luma_nr_consts.svh"

module sd_luma_noise_reduction (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire luma_nr_pkg::pix_in_t pix_in,
  output luma_nr_pkg::pix_out_t     pix_out,
  input  wire logic [9:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);
  import luma_nr_pkg::*;

  function automatic logic [2:0] reg_decode(input logic [9:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    reg_decode = 3'b000;
    if (addr[1:0] == 2'b00 && idx >= `IDX_GAIN && idx <= `IDX_MODE_OFF) begin
      reg_decode = {1'b1, 2'(idx - `IDX_GAIN)};
    end
  endfunction

  function automatic logic signed [10:0] lum(input logic [7:0] v);
    lum = $signed({3'b000, v});
  endfunction

  // high-pass responses centred on the middle of five taps
  function automatic logic signed [10:0] hp(input filt_sel_t sel, input logic [4:0][7:0] y);
    logic signed [10:0] n3;
    logic signed [10:0] w3;
    logic signed [10:0] n5;
    n3 = (lum(y[2]) <<< 1) - lum(y[1]) - lum(y[3]);
    w3 = (lum(y[2]) <<< 1) - lum(y[0]) - lum(y[4]);
    n5 = (lum(y[2]) <<< 2) - lum(y[0]) - lum(y[1]) - lum(y[3]) - lum(y[4]);
    case (sel)
      FILT_HALF3:  hp = n3 >>> 1;
      FILT_FULL3:  hp = n3;
      FILT_WIDE3:  hp = w3;
      FILT_HALF5:  hp = n5 >>> 1;
      FILT_QUART5: hp = n5 >>> 2;
      FILT_DIFF:   hp = lum(y[2]) - lum(y[3]);
      FILT_HWIDE:  hp = w3 >>> 1;
      default:     hp = 11'sd0;
    endcase
  endfunction

  logic [2:0][7:0] cfg_ff;
  logic            wait_ff;
  logic [31:0]     rdata_ff;
  logic            phase_ff;
  logic [3:0]      hpos_ff;
  logic [3:0]      vpos_ff;
  logic [4:0][7:0] y_ff;
  logic [4:0]      bd_ff;
  pix_out_t        out_ff;

  // register bus
  wire [2:0] dec      = reg_decode(avs_address);
  wire       hit      = dec[2];
  wire [1:0] ridx     = dec[1:0];
  wire       req      = avs_read | avs_write;
  wire       take     = req & wait_ff;
  wire       wr_en    = avs_write & ~wait_ff & hit & avs_byteenable[0];
  wire [7:0] rd_byte  = hit ? cfg_ff[ridx] : 8'h00;
  wire       nxt_wait = ~take;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // writes land on the edge where the master sees waitrequest low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= {3{`CFG_RESET}};
    end else if (wr_en) begin
      cfg_ff[ridx] <= avs_writedata[7:0];
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // configuration fields
  wire [7:0]  r_gain    = cfg_ff[0];
  wire [7:0]  r_thr     = cfg_ff[1];
  wire [7:0]  r_mode    = cfg_ff[2];
  wire [3:0]  g_bord    = r_gain[`GAIN_BORD_LSB +: 4];
  wire [3:0]  g_data    = r_gain[`GAIN_DATA_LSB +: 4];
  wire [5:0]  thr       = r_thr[`THR_LSB +: 6];
  wire        wide      = r_thr[`BORDER_BIT];
  wire        blk16     = r_thr[`BLK16_BIT];
  filt_sel_t  fsel;
  assign fsel = filt_sel_t'(r_mode[`SEL_LSB +: 3]);
  // mode bit and offset field share bit 4, exactly as laid out
  wire        sharp     = r_mode[`MODE_BIT];
  wire [3:0]  offset    = r_mode[`OFF_LSB +: 4];

  // block grid geometry
  wire [4:0]  blk       = blk16 ? `BLK_LARGE : `BLK_SMALL;
  wire [3:0]  blk_mask  = 4'(blk - 5'd1);
  wire [4:0]  half      = wide ? `HALF_WIDE : `HALF_NARROW;
  wire [3:0]  off_pos   = offset & blk_mask;

  // pixel framing: a pixel is two valid cycles, luma on the first
  wire        sol       = pix_in.valid & pix_in.sol;
  wire        sof       = pix_in.valid & pix_in.sof;
  wire        ph0       = pix_in.valid & (sol | ~phase_ff);
  wire        pix_end   = pix_in.valid & phase_ff & ~sol;
  // phase high means the next valid cycle carries chroma
  wire        nxt_phase = pix_in.valid ? ph0 : phase_ff;

  wire [3:0]  cur_h     = sol ? off_pos : hpos_ff;
  wire [3:0]  v_inc     = 4'(vpos_ff + 4'd1) & blk_mask;
  wire [3:0]  cur_v     = sof ? 4'h0 : (sol ? v_inc : vpos_ff);
  wire [3:0]  h_inc     = 4'(cur_h + 4'd1) & blk_mask;
  wire [3:0]  nxt_hpos  = pix_end ? h_inc : cur_h;

  // transition area straddles each block edge, half on either side
  function automatic logic in_border(input logic [3:0] pos, input logic [4:0] size, input logic [4:0] hw);
    in_border = ({1'b0, pos} < hw) | ({1'b0, pos} >= 5'(size - hw));
  endfunction

  wire        h_bord    = in_border(cur_h, blk, half);
  wire        v_bord    = in_border(cur_v, blk, half);
  wire        border    = h_bord | v_bord;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= 1'b0;
      hpos_ff  <= 4'h0;
      vpos_ff  <= 4'h0;
    end else begin
      phase_ff <= nxt_phase;
      hpos_ff  <= nxt_hpos;
      vpos_ff  <= cur_v;
    end
  end

  // luma history; chroma cycles never enter it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      y_ff  <= '0;
      bd_ff <= 5'h00;
    end else if (ph0) begin
      y_ff  <= {y_ff[3:0], pix_in.luma};
      bd_ff <= {bd_ff[3:0], border};
    end
  end

  // noise decision and correction on the centre tap
  wire [7:0]         centre = y_ff[2];
  wire signed [10:0] filt   = hp(fsel, y_ff);
  wire [9:0]         mag    = filt[10] ? 10'(-filt) : filt[9:0];
  wire               below  = mag < {4'h0, thr};
  wire               above  = mag > {4'h0, thr};
  wire               apply  = sharp ? above : below;
  wire [3:0]         g_raw  = bd_ff[2] ? g_bord : g_data;
  // codes above eight saturate so the factor tops out at one or one half
  wire [3:0]         g_sat  = (g_raw > `GAIN_MAX) ? `GAIN_MAX : g_raw;
  wire signed [15:0] prod   = filt * $signed({1'b0, g_sat});
  wire signed [15:0] corr   = sharp ? (prod >>> `SHARP_SHIFT)
                                    : (prod >>> `CORE_SHIFT);
  wire signed [15:0] c16    = $signed({8'h00, centre});
  wire signed [15:0] sum    = !apply ? c16
                            : (sharp ? c16 + corr : c16 - corr);
  wire [7:0]         sat    = sum[15] ? 8'h00
                            : (sum > $signed({8'h00, `LUMA_MAX}) ? `LUMA_MAX : sum[7:0]);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_ff <= '0;
    end else begin
      out_ff.valid <= ph0;
      out_ff.luma  <= ph0 ? sat : out_ff.luma;
    end
  end

  assign pix_out = out_ff;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_bus_ack;
    req && wait_ff |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle late");

  property p_reg_write;
    logic [1:0] i;
    logic [7:0] d;
    (wr_en, i = ridx, d = avs_writedata[7:0]) |=> cfg_ff[i] == d;
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("register write lost");

  property p_core_keep;
    ph0 && !sharp && mag >= {4'h0, thr} |=> pix_out.luma == $past(centre);
  endproperty
  a_core_keep: assert property (p_core_keep) else $error("coring touched signal");

  property p_core_sub;
    ph0 && !sharp && below && filt > 0 && g_sat != 0 |=> pix_out.luma <= $past(centre);
  endproperty
  a_core_sub: assert property (p_core_sub) else $error("coring did not subtract");

  property p_sharp_keep;
    ph0 && sharp && !above |=> pix_out.luma == $past(centre);
  endproperty
  a_sharp_keep: assert property (p_sharp_keep) else $error("sharpening touched noise");

  property p_sharp_add;
    ph0 && sharp && above && filt > 0 |=> pix_out.luma >= $past(centre);
  endproperty
  a_sharp_add: assert property (p_sharp_add) else $error("sharpening did not add");

  property p_zero_gain;
    ph0 && g_raw == 4'h0 |=> pix_out.luma == $past(centre);
  endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("zero gain changed luma");

  // a stale position may exceed a freshly shrunk block until the next step
  property p_blk_range;
    sol || pix_end |=> {1'b0, hpos_ff} < $past(blk) && (!$past(sol) || {1'b0, vpos_ff} < $past(blk));
  endproperty
  a_blk_range: assert property (p_blk_range) else $error("position beyond block");

  property p_width;
    pix_in.valid && !sol && hpos_ff == 4'h1 && vpos_ff == 4'h3 |-> border == wide;
  endproperty
  a_width: assert property (p_width) else $error("border width wrong");

  property p_hold_phase;
    !pix_end && !sol |=> $stable(hpos_ff);
  endproperty
  a_hold_phase: assert property (p_hold_phase) else $error("position moved mid pixel");

  property p_line_start;
    sol |=> hpos_ff == $past(off_pos) ##1 hpos_ff == $past(h_inc);
  endproperty
  a_line_start: assert property (p_line_start) else $error("line start misplaced");

  property p_rd_hit;
    avs_read && !avs_waitrequest && hit |-> avs_readdata == {24'h00_0000, cfg_ff[ridx]};
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read data wrong");

  property p_rd_miss;
    avs_read && !avs_waitrequest && !hit |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");

  property p_rd_quiet;
    avs_waitrequest |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");

  property p_wait_idle;
    !req |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

  property p_wr_masked;
    avs_write && !avs_waitrequest && !avs_byteenable[0] |=> $stable(cfg_ff);
  endproperty
  a_wr_masked: assert property (p_wr_masked) else $error("masked write landed");

  property p_pulse_luma;
    sol |=> pix_out.valid;
  endproperty
  a_pulse_luma: assert property (p_pulse_luma) else $error("no pulse after line start");

  property p_pulse_chroma;
    pix_end |=> !pix_out.valid;
  endproperty
  a_pulse_chroma: assert property (p_pulse_chroma) else $error("pulse after chroma cycle");

  property p_out_hold;
    !ph0 |=> $stable(pix_out.luma);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved between pixels");

  property p_luma_only;
    !ph0 |=> $stable(y_ff);
  endproperty
  a_luma_only: assert property (p_luma_only) else $error("chroma entered history");

  property p_y_pipe;
    ph0 |=> y_ff[0] == $past(pix_in.luma);
  endproperty
  a_y_pipe: assert property (p_y_pipe) else $error("luma not captured");

  property p_bd_pipe;
    ph0 |=> bd_ff[0] == $past(border);
  endproperty
  a_bd_pipe: assert property (p_bd_pipe) else $error("border flag not captured");

  property p_clip_high;
    ph0 && sum > 16'sh00ff |=> pix_out.luma == `LUMA_MAX;
  endproperty
  a_clip_high: assert property (p_clip_high) else $error("overflow not clipped");

  property p_clip_low;
    ph0 && sum < 16'sh0000 |=> pix_out.luma == 8'h00;
  endproperty
  a_clip_low: assert property (p_clip_low) else $error("underflow not clipped");

  property p_field_start;
    sof |=> vpos_ff == 4'h0;
  endproperty
  a_field_start: assert property (p_field_start) else $error("field start misplaced");

  property p_line_step;
    sol && !sof |=> vpos_ff == 4'(($past(vpos_ff) + 4'h1) & $past(blk_mask));
  endproperty
  a_line_step: assert property (p_line_step) else $error("row count wrong");

  property p_bord_gain0;
    ph0 && bd_ff[2] && g_bord == 4'h0 |=> pix_out.luma == $past(centre);
  endproperty
  a_bord_gain0: assert property (p_bord_gain0) else $error("zero border gain changed luma");

  property p_data_gain0;
    ph0 && !bd_ff[2] && g_data == 4'h0 |=> pix_out.luma == $past(centre);
  endproperty
  a_data_gain0: assert property (p_data_gain0) else $error("zero data gain changed luma");

  property p_filter_off;
    ph0 && fsel == FILT_OFF |=> pix_out.luma == $past(centre);
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("disabled filter changed luma");

  property p_thr_edge;
    ph0 && mag == {4'h0, thr} |=> pix_out.luma == $past(centre);
  endproperty
  a_thr_edge: assert property (p_thr_edge) else $error("equal magnitude processed");

  c_core:   cover property (ph0 && !sharp && below && filt != 0 && g_sat != 0);
  c_sharp:  cover property (ph0 && sharp && above && g_sat != 0);
  c_write:  cover property (wr_en && ridx == 2'd2);
  c_border: cover property (ph0 && border && blk16 && wide);

endmodule

//--- dv/pix_source.sv
/*
  Pixel source standing upstream of the luma noise reduction stage.
  Sends LINES lines of PIXELS pixels per start pulse, luma cycle then chroma
  cycle, with an idle cycle between lines. Assumes ref_clk and resetn of the bench.
*/
`timescale 1ns/1ps
module pix_source #(
  parameter int LINES  = 4,
  parameter int PIXELS = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             start,
  output luma_nr_pkg::pix_in_t  pix,
  output logic                  busy
);
  import luma_nr_pkg::*;
  int   line;
  int   pixn;
  logic ph;
  logic gap;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pix  <= '0;
      busy <= 1'b0;
      line <= 0;
      pixn <= 0;
      ph   <= 1'b0;
      gap  <= 1'b0;
    end else if (!busy || gap) begin
      // released lines show inverted data so stale values never look valid
      pix.valid <= 1'b0;
      pix.sol   <= 1'b0;
      pix.sof   <= 1'b0;
      pix.luma  <= ~pix.luma;
      gap       <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        line <= 0;
        pixn <= 0;
        ph   <= 1'b0;
      end
    end else begin
      pix.valid <= 1'b1;
      pix.sol   <= !ph && pixn == 0;
      pix.sof   <= !ph && pixn == 0 && line == 0;
      // alternating luma keeps every filter tap consistent across line ends
      pix.luma  <= ph ? 8'h80 : (pixn[0] ? 8'h68 : 8'h64);
      ph        <= !ph;
      if (ph) begin
        pixn <= (pixn == PIXELS - 1) ? 0 : pixn + 1;
        if (pixn == PIXELS - 1) begin
          gap  <= 1'b1;
          line <= line + 1;
          busy <= line != LINES - 1;
        end
      end
    end
  end
endmodule

//--- dv/sd_luma_noise_reduction_tb.sv
/*
  Self-checking bench: registers over Avalon-MM, then corrected luma for a
  table of settings against a reference model. Assumes package and header.
*/
`timescale 1ns/1ps
module sd_luma_noise_reduction_tb;
  import luma_nr_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       start = 1'b0;
  logic       busy;
  pix_in_t    pix_in;
  pix_out_t   pix_out;
  logic [9:0] avs_address = 10'h000;
  logic       avs_read = 1'b0;
  logic       avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic       avs_waitrequest;
  logic [31:0] rd;
  logic [7:0] c3, c4, c5;
  int         err_count = 0;
  int         check_count = 0;
  int         pcnt = 0;
  int         n;
  // gain, threshold/block, select/mode/offset; mode bit shares the offset field
  logic [23:0] tbl [14] = '{24'h82_0901, 24'h35_4921, 24'hc4_8841, 24'h5a_c9e1,
                            24'h83_0711, 24'h3c_c7f1, 24'h88_0831, 24'h88_3f07,
                            24'h48_0500, 24'h8f_8114, 24'h6b_4605, 24'h3a_0a02,
                            24'h3a_0016, 24'h8f_c313};

  sd_luma_noise_reduction DUT (.ref_clk(ref_clk), .resetn(resetn), .pix_in(pix_in), .pix_out(pix_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  pix_source src (.ref_clk(ref_clk), .resetn(resetn), .start(start), .pix(pix_in), .busy(busy));

  always #25 ref_clk = ~ref_clk;

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) begin
      err_count++;
      complete_run();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [7:0] exp_pix(int p);
    int i, r, blk, hf, col, g, f, y, m, e;
    i = p % 32;
    r = p / 32;
    y = i[0] ? 104 : 100;
    // odd pixels sit four above their neighbours, even ones four below
    e = i[0] ? 1 : -1;
    case (c5[2:0])
      3'd0, 3'd3, 3'd5: f = 4 * e;
      3'd1:             f = 8 * e;
      3'd4:             f = 2 * e;
      default:          f = 0;
    endcase
    m = (f < 0) ? -f : f;
    blk = c4[7] ? 16 : 8;
    hf = c4[6] ? 2 : 1;
    col = (c5[7:4] + i) % blk;
    g = (col < hf || col >= blk - hf || r < hf || r >= blk - hf) ? c3[3:0] : c3[7:4];
    if (g > 8)
      g = 8;
    if (!c5[4] && m < c4[5:0])
      y = y - ((f * g) >>> 3);
    if (c5[4] && m > c4[5:0])
      y = y + ((f * g) >>> 4);
    y = (y > 255) ? 255 : ((y < 0) ? 0 : y);
    return y[7:0];
  endfunction

  // a pulse carries the pixel three before the newest; skip pixels lacking true neighbours
  always @(posedge ref_clk) begin
    if (pix_out.valid === 1'b1) begin
      if (pcnt >= 5 && pcnt <= 127)
        chk("luma", {24'h00_0000, exp_pix(pcnt - 3)}, {24'h00_0000, pix_out.luma});
      pcnt++;
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, 10'h28c + 10'(4 * k), 32'h0000_0000, 4'hf);
      chk("reset_value", 32'h0000_0000, rd);
    end
    bus(1'b1, 10'h28c, 32'h1234_56a5, 4'hf);
    bus(1'b1, 10'h28c, 32'h0000_0011, 4'he);
    bus(1'b0, 10'h28c, 32'h0000_0000, 4'hf);
    chk("gain_reg", 32'h0000_00a5, rd);
    bus(1'b0, 10'h298, 32'h0000_0000, 4'hf);
    chk("unmapped", 32'h0000_0000, rd);
    foreach (tbl[t]) begin
      for (int k = 0; k < 3; k++) begin
        bus(1'b1, 10'h28c + 10'(4 * k), {24'h00_0000, tbl[t][23 - 8 * k -: 8]}, 4'hf);
        bus(1'b0, 10'h28c + 10'(4 * k), 32'h0000_0000, 4'hf);
        chk("cfg_reg", {24'h00_0000, tbl[t][23 - 8 * k -: 8]}, rd);
      end
      {c3, c4, c5} = tbl[t];
      pcnt = 0;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while ((busy !== 1'b0 || n < 2) && n < 2000);
      if (n >= 2000) begin
        err_count++;
        complete_run();
      end
      repeat (2) @(posedge ref_clk);
      chk("pulse_count", 32'd128, 32'(pcnt));
    end
    complete_run();
  end
endmodule
